// ### fcd_flash_command_decoder.sv
// Flash command decoder: turns CPU bus writes into array read, status, program and erase actions.
// Assumes the CPU drives one access per cycle, synchronous to core_clk, with flash
// array data and sequencer status supplied by the surrounding flash macro.
//
// Overview of operation
// - Commands and data are 16-bit accesses to even addresses in the user ROM area.
// - Only the low byte of a command write is decoded; the high byte is ignored.
// - Writing FF hex enters array read mode and following reads return array words.
// - Array read mode holds until 70, 40 or 20 hex is written.
// - After writing 70 hex the next read returns the 8-bit status on the low data bits.
// - Writing 50 hex clears the two upper control flags and status bits 4 and 5.
// - Programming writes 40 hex and then the data word to the same even address.
// - Erase writes 20 hex anywhere and then D0 hex to the block's highest even address.
`timescale 1ns/1ps

module fcd_flash_command_decoder (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    // CPU bus
    input  wire fcd_pkg::fcd_bus_t      cpu_bus,
    input  wire logic                   in_user_rom,
    output logic [15:0]                 cpu_rdata,
    // Flash array and sequencer status
    input  wire logic [15:0]            array_rdata,
    input  wire logic [7:0]             seq_status,
    input  wire logic                   set_status_bit4,
    input  wire logic                   set_status_bit5,
    input  wire logic                   set_ctl_flags,
    input  wire logic                   erase_write_mode_one,
    // Operations to the sequencer
    output fcd_pkg::fcd_op_t            program_op,
    output fcd_pkg::fcd_op_t            erase_op,
    output logic [7:0]                  status_read_value,
    output logic                        flash_ctl0_flag_bit6,
    output logic                        flash_ctl0_flag_bit7,
    output logic                        bad_access
);

    // ************************************************************
    // Decode
    // ************************************************************
    fcd_pkg::fcd_state_t     state_q, state_d;
    logic [fcd_pkg::ADDR_W-1:0] program_target_address_q, program_target_address_d;
    fcd_pkg::fcd_op_t        prog_q, prog_d, erase_q, erase_d;
    logic [15:0]             rdata_q, rdata_d;
    logic                    st4_q, st4_d, st5_q, st5_d;
    logic [1:0]              ctl_q, ctl_d;
    logic                    bad_q, bad_d;
    logic                    legal;
    logic [7:0]              cmd;
    logic [7:0]              sts_view;

    // Odd or out-of-area accesses are dropped so a stray byte write never starts a sequence.
    assign legal    = in_user_rom && !cpu_bus.addr[0];
    assign cmd      = cpu_bus.wdata[7:0];
    assign sts_view = {seq_status[7:6], st5_q, st4_q, seq_status[3:0]};

    always_comb begin
        state_d  = state_q;
        program_target_address_d = program_target_address_q;
        prog_d   = '0;
        erase_d  = '0;
        rdata_d  = rdata_q;
        st4_d    = st4_q | set_status_bit4;
        st5_d    = st5_q | set_status_bit5;
        ctl_d    = ctl_q | {2{set_ctl_flags}};
        bad_d    = (cpu_bus.wr || cpu_bus.rd) && !legal;
        if (cpu_bus.rd && legal) begin
            if (state_q == fcd_pkg::FCD_STATUS) begin
                rdata_d = {8'h00, sts_view};
            end else begin
                rdata_d = array_rdata;
            end
        end
        if (cpu_bus.wr && legal) begin
            case (state_q)
                fcd_pkg::FCD_PROG_WD: begin
                    // A different address means the word is not meant for this program cycle.
                    if (cpu_bus.addr == program_target_address_q) begin
                        prog_d.go   = 1'b1;
                        prog_d.addr = cpu_bus.addr;
                        prog_d.data = cpu_bus.wdata;
                    end
                    state_d = fcd_pkg::FCD_ARRAY;
                end
                fcd_pkg::FCD_ERASE_C: begin
                    if (cmd == fcd_pkg::CMD_ERASE_OK) begin
                        erase_d.go   = 1'b1;
                        erase_d.addr = cpu_bus.addr;
                        erase_d.data = cpu_bus.wdata;
                    end
                    state_d = fcd_pkg::FCD_ARRAY;
                end
                default: begin
                    if (cmd == fcd_pkg::CMD_READ_ARR) begin
                        state_d = fcd_pkg::FCD_ARRAY;
                    end else if (cmd == fcd_pkg::CMD_READ_STS) begin
                        state_d = fcd_pkg::FCD_STATUS;
                    end else if (cmd == fcd_pkg::CMD_CLR_STS) begin
                        // Clear loses to a same-cycle set so no event goes missing.
                        st4_d = set_status_bit4;
                        st5_d = set_status_bit5;
                        ctl_d = {2{set_ctl_flags}};
                    end else if (cmd == fcd_pkg::CMD_PROGRAM) begin
                        state_d = fcd_pkg::FCD_PROG_WD;
                        program_target_address_d = cpu_bus.addr;
                    end else if (cmd == fcd_pkg::CMD_ERASE) begin
                        state_d = fcd_pkg::FCD_ERASE_C;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= fcd_pkg::FCD_ARRAY;
            program_target_address_q <= '0;
            prog_q   <= '0;
            erase_q  <= '0;
            rdata_q  <= 16'h0000;
            st4_q    <= 1'b0;
            st5_q    <= 1'b0;
            ctl_q    <= fcd_pkg::CTL_FLAGS_RST;
            bad_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            program_target_address_q <= program_target_address_d;
            prog_q   <= prog_d;
            erase_q  <= erase_d;
            rdata_q  <= rdata_d;
            st4_q    <= st4_d;
            st5_q    <= st5_d;
            ctl_q    <= ctl_d;
            bad_q    <= bad_d;
        end
    end

    assign cpu_rdata            = rdata_q;
    assign program_op           = prog_q;
    assign erase_op             = erase_q;
    assign status_read_value    = sts_view;
    assign flash_ctl0_flag_bit6 = ctl_q[0];
    assign flash_ctl0_flag_bit7 = ctl_q[1];
    assign bad_access           = bad_q;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_prog_pair;
        @(posedge core_clk) disable iff (!reset_n)
        program_op.go |-> $past(state_q) == fcd_pkg::FCD_PROG_WD
            && program_op.addr == $past(program_target_address_q);
    endproperty
    a_prog_pair: assert property (p_prog_pair) else $error("program without 40h setup");

    property p_erase_pair;
        @(posedge core_clk) disable iff (!reset_n)
        erase_op.go |-> $past(state_q) == fcd_pkg::FCD_ERASE_C && erase_op.data[7:0] == 8'hd0;
    endproperty
    a_erase_pair: assert property (p_erase_pair) else $error("erase without confirm");

    property p_abandon;
        @(posedge core_clk) disable iff (!reset_n)
        (state_q == fcd_pkg::FCD_ERASE_C && cpu_bus.wr && legal && cmd != 8'hd0)
            |=> !erase_op.go && state_q == fcd_pkg::FCD_ARRAY;
    endproperty
    a_abandon: assert property (p_abandon) else $error("bad erase confirm not dropped");

    property p_status_read;
        @(posedge core_clk) disable iff (!reset_n)
        (state_q == fcd_pkg::FCD_STATUS && cpu_bus.rd && legal)
            |=> cpu_rdata == {8'h00, $past(sts_view)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_array_read;
        @(posedge core_clk) disable iff (!reset_n)
        (state_q == fcd_pkg::FCD_ARRAY && cpu_bus.rd && legal)
            |=> cpu_rdata == $past(array_rdata);
    endproperty
    a_array_read: assert property (p_array_read) else $error("array read wrong");

    property p_hold_array;
        @(posedge core_clk) disable iff (!reset_n)
        (state_q == fcd_pkg::FCD_ARRAY && !cpu_bus.wr) |=> state_q == fcd_pkg::FCD_ARRAY;
    endproperty
    a_hold_array: assert property (p_hold_array) else $error("left array mode");

    property p_clear;
        @(posedge core_clk) disable iff (!reset_n)
        (state_q inside {fcd_pkg::FCD_ARRAY, fcd_pkg::FCD_STATUS} && cpu_bus.wr && legal
            && cmd == 8'h50 && !set_status_bit4 && !set_status_bit5 && !set_ctl_flags)
            |=> !st4_q && !st5_q && ctl_q == 2'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear status failed");

    property p_set_wins;
        @(posedge core_clk) disable iff (!reset_n)
        set_status_bit4 |=> status_read_value[4];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status bit 4 set lost");

    property p_flags_set;
        @(posedge core_clk) disable iff (!reset_n)
        set_ctl_flags |=> flash_ctl0_flag_bit6 && flash_ctl0_flag_bit7;
    endproperty
    a_flags_set: assert property (p_flags_set) else $error("control flag set lost");

    property p_bad_drop;
        @(posedge core_clk) disable iff (!reset_n)
        ((cpu_bus.wr || cpu_bus.rd) && !legal)
            |=> !program_op.go && !erase_op.go && $stable(cpu_rdata);
    endproperty
    a_bad_drop: assert property (p_bad_drop) else $error("refused access had effect");

    property p_high_byte;
        @(posedge core_clk) disable iff (!reset_n)
        (state_q == fcd_pkg::FCD_ARRAY && cpu_bus.wr && legal && cmd == 8'h20)
            |=> state_q == fcd_pkg::FCD_ERASE_C;
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("command not decoded");

    property p_odd;
        @(posedge core_clk) disable iff (!reset_n)
        (cpu_bus.wr && cpu_bus.addr[0]) |=> $stable(state_q) && bad_access;
    endproperty
    a_odd: assert property (p_odd) else $error("odd access accepted");

endmodule : fcd_flash_command_decoder

// ### fcd_pkg.sv
// Package for the flash command decoder: command codes, state encoding and bus carriers.
// Assumes a 16-bit CPU bus with word-addressed even byte addresses.
package fcd_pkg;

    localparam int          ADDR_W       = 20;
    localparam logic [7:0]  CMD_READ_ARR = 8'hff;
    localparam logic [7:0]  CMD_READ_STS = 8'h70;
    localparam logic [7:0]  CMD_CLR_STS  = 8'h50;
    localparam logic [7:0]  CMD_PROGRAM  = 8'h40;
    localparam logic [7:0]  CMD_ERASE    = 8'h20;
    localparam logic [7:0]  CMD_ERASE_OK = 8'hd0;
    localparam int          STS_BIT4     = 4;
    localparam int          STS_BIT5     = 5;
    localparam logic [7:0]  STS_RESET    = 8'h80;
    localparam logic [1:0]  CTL_FLAGS_RST = 2'h0;

    typedef enum logic [2:0] {
        FCD_ARRAY   = 3'b000,
        FCD_STATUS  = 3'b001,
        FCD_PROG_WD = 3'b010,
        FCD_ERASE_C = 3'b011
    } fcd_state_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       wdata;
    } fcd_bus_t;

    typedef struct packed {
        logic              go;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       data;
    } fcd_op_t;

endpackage : fcd_pkg

// ### fcd_cpu_model.sv
// CPU bus master model: issues single-cycle word reads and writes to the decoder.
// Assumes each access is started just after a rising edge of core_clk.
`timescale 1ns/1ps
module fcd_cpu_model (
    // Clock
    input  wire logic          core_clk,
    // CPU bus
    output fcd_pkg::fcd_bus_t  cpu_bus,
    output logic               in_user_rom
);
    initial begin
        cpu_bus     = '0;
        in_user_rom = 1'b0;
    end
    // ************************************************************
    // Access
    // ************************************************************
    // Between accesses the strobes are cleared and address and data inverted, so a stale value never looks valid.
    task automatic access(input logic wr, input logic [19:0] addr, input logic [15:0] data,
                          input logic rom);
        // An idle edge before each access keeps back-to-back calls from rewriting the strobe
        // in the time step that released it.
        @(posedge core_clk);
        #1;
        cpu_bus.wr    = wr;
        cpu_bus.rd    = ~wr;
        cpu_bus.addr  = addr;
        cpu_bus.wdata = data;
        in_user_rom   = rom;
        @(posedge core_clk);
        #1;
        cpu_bus     = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
        in_user_rom = 1'b0;
    endtask : access
endmodule : fcd_cpu_model

// ### flash_command_decoder_tb_top.sv
// Testbench for the flash command decoder: command sequences with expected results.
// Assumes the CPU model drives the bus and a simple array image answers reads.
`timescale 1ns/1ps
module flash_command_decoder_tb_top;
    logic              core_clk;
    logic              reset_n;
    fcd_pkg::fcd_bus_t cpu_bus;
    logic              in_user_rom;
    logic [15:0]       cpu_rdata;
    logic [15:0]       array_rdata;
    logic              set_status_bit4;
    logic              set_status_bit5;
    logic              set_ctl_flags;
    fcd_pkg::fcd_op_t  program_op;
    fcd_pkg::fcd_op_t  erase_op;
    logic [7:0]        status_read_value;
    logic              flash_ctl0_flag_bit6;
    logic              flash_ctl0_flag_bit7;
    logic              bad_access;
    int                err_count;
    int                num_checks;

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    assign array_rdata = cpu_bus.addr[15:0] ^ 16'h5a5a;

    fcd_cpu_model cpu_u (.core_clk(core_clk), .cpu_bus(cpu_bus), .in_user_rom(in_user_rom));
    fcd_flash_command_decoder dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .cpu_bus(cpu_bus), .in_user_rom(in_user_rom),
        .cpu_rdata(cpu_rdata), .array_rdata(array_rdata), .seq_status(8'hb1),
        .set_status_bit4(set_status_bit4), .set_status_bit5(set_status_bit5),
        .set_ctl_flags(set_ctl_flags), .erase_write_mode_one(1'b0),
        .program_op(program_op), .erase_op(erase_op), .status_read_value(status_read_value),
        .flash_ctl0_flag_bit6(flash_ctl0_flag_bit6), .flash_ctl0_flag_bit7(flash_ctl0_flag_bit7),
        .bad_access(bad_access));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        cpu_u.access(1'b1, a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [19:0] a);
        cpu_u.access(1'b0, a, 16'h0000, 1'b1);
    endtask : rd
    task automatic pulse(input logic b4, input logic b5, input logic fl);
        {set_status_bit4, set_status_bit5, set_ctl_flags} = {b4, b5, fl};
        @(posedge core_clk);
        #1;
        {set_status_bit4, set_status_bit5, set_ctl_flags} = 3'h0;
    endtask : pulse
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        {err_count, num_checks} = '0;
        reset_n = 1'b0;
        {set_status_bit4, set_status_bit5, set_ctl_flags} = 3'h0;
        repeat (4) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        check(40'(status_read_value), 40'h81);
        wr(20'h01000, 16'h12ff);
        rd(20'h01000);
        check(40'(cpu_rdata), 40'(16'h01000 ^ 16'h5a5a));
        rd(20'h03456);
        check(40'(cpu_rdata), 40'(16'h3456 ^ 16'h5a5a));
        pulse(1'b1, 1'b0, 1'b0);
        wr(20'h01000, 16'hee70);
        rd(20'h01002);
        check(40'(cpu_rdata), 40'h91);
        rd(20'h01004);
        check(40'(cpu_rdata), 40'h91);
        pulse(1'b0, 1'b1, 1'b1);
        check(40'({flash_ctl0_flag_bit7, flash_ctl0_flag_bit6}), 40'h3);
        check(40'(status_read_value), 40'hb1);
        wr(20'h01000, 16'h7750);
        check(40'({flash_ctl0_flag_bit7, flash_ctl0_flag_bit6}), 40'h0);
        check(40'(status_read_value), 40'h81);
        wr(20'h02000, 16'h3440);
        wr(20'h02000, 16'hbeef);
        check(40'(program_op), 40'({1'b1, 20'h02000, 16'hbeef}));
        wr(20'h02000, 16'h0040);
        wr(20'h02002, 16'hbeef);
        check(40'(program_op.go), 40'h0);
        rd(20'h02000);
        check(40'(cpu_rdata), 40'(16'h2000 ^ 16'h5a5a));
        wr(20'h01000, 16'h0020);
        wr(20'h07ffe, 16'hffd0);
        check(40'({erase_op.go, erase_op.addr}), 40'({1'b1, 20'h07ffe}));
        wr(20'h01000, 16'h0020);
        wr(20'h07ffe, 16'h00d1);
        check(40'(erase_op.go), 40'h0);
        wr(20'h01001, 16'h00ff);
        check(40'(bad_access), 40'h1);
        cpu_u.access(1'b0, 20'h04000, 16'h0000, 1'b0);
        check(40'(bad_access), 40'h1);
        check(40'(cpu_rdata), 40'(16'h2000 ^ 16'h5a5a));
        // A set that meets a clear in the same cycle must survive it.
        fork
            wr(20'h01000, 16'h0050);
            begin
                @(posedge core_clk);
                #1;
                pulse(1'b1, 1'b0, 1'b0);
            end
        join
        check(40'(status_read_value), 40'h91);
        check(40'({flash_ctl0_flag_bit7, flash_ctl0_flag_bit6}), 40'h0);
        test_done();
    end
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule : flash_command_decoder_tb_top
